/* scg_unit.sv */
// processor-side get/put unit for eight input and eight output stream channels
`timescale 1ns/100ps
`default_nettype none
// Contract
// - eight independent input and eight independent output channels, each point to point.
// - each channel carries words one way between two endpoints, never shared.
// - every channel data path is 32 bits wide.
// - each word travels with one tag bit marking control or data.
// - blocking data read stalls while channel empty, then completes in two cycles.
// - blocking data read of a control-tagged word sets error bit 27.
// - non-blocking data read stalls only while the write-back buffer is full, two cycles, carry bit 29 shows success.
// - status bit 0 always mirrors the carry flag.
// - non-blocking data read of a control-tagged word sets error bit 27.
// - blocking control read stalls while channel empty, then completes in two cycles.
// - blocking control read of a data-tagged word sets error bit 27.
// - non-blocking control read: stalls only on a full write-back buffer, two cycles, carry result, data tag errors.
// - blocking data write stalls while full, completes in two cycles, tag low.
// - non-blocking data write: no stall, two cycles, tag low, carry shows acceptance.
// - blocking control write stalls while full, completes in two cycles, tag high.
// - non-blocking control write: no stall, two cycles, tag high, carry shows acceptance.
module scg_unit (
  input  wire logic                                   clk,
  input  wire logic                                   nrst,
  // instruction request from the pipeline
  input  wire logic                                   opValid,
  input  wire logic                                   opPut,
  input  wire logic                                   opNonBlock,
  input  wire logic                                   opControl,
  input  wire logic [scg_pkg::CH_W-1:0]               opChannel,
  input  wire logic [scg_pkg::TGT_W-1:0]              opTarget,
  input  wire logic [scg_pkg::DATA_W-1:0]             opWord,
  output logic                                        opReady,
  output logic                                        opDone,
  // input channels
  input  wire logic [scg_pkg::NUM_CH-1:0]             chInValid,
  input  wire logic [scg_pkg::NUM_CH-1:0][scg_pkg::DATA_W-1:0] chInData,
  input  wire logic [scg_pkg::NUM_CH-1:0]             chInCtrl,
  output logic      [scg_pkg::NUM_CH-1:0]             chInRead,
  // output channels
  input  wire logic [scg_pkg::NUM_CH-1:0]             chOutFull,
  output logic      [scg_pkg::NUM_CH-1:0][scg_pkg::DATA_W-1:0] chOutData,
  output logic      [scg_pkg::NUM_CH-1:0]             chOutCtrl,
  output logic      [scg_pkg::NUM_CH-1:0]             chOutWrite,
  // status flags
  input  wire logic                                   errClear,
  output logic                                        carryFlag,
  output logic                                        errorFlag,
  output logic      [31:0]                            statusWord,
  // register write-back of read results
  output logic                                        wbValid,
  input  wire logic                                   wbReady,
  output logic      [scg_pkg::TGT_W-1:0]              wbTarget,
  output logic      [scg_pkg::DATA_W-1:0]             wbWord
);
  localparam int WB_W = scg_pkg::TGT_W + scg_pkg::DATA_W;
  logic [scg_pkg::NUM_CH-1:0] chOneHot; // decoded channel, shared by read and write strobes

  // channel index to one-hot strobe, used for reads and writes
  function automatic logic [scg_pkg::NUM_CH-1:0] chSel(input logic [scg_pkg::CH_W-1:0] idx);
    logic [scg_pkg::NUM_CH-1:0] v;
    v      = '0;
    v[idx] = 1'b1;
    return v;
  endfunction

  scg_pkg::scg_state_t state_q;
  scg_pkg::scg_state_t state_d;
  logic                idle;
  logic                inAvail;
  logic                inIsCtrl;
  logic                outFull;
  logic                getGo;
  logic                putGo;
  logic                tookWord;
  logic                putOk;
  logic                tagMismatch;
  logic                wbInReady;
  logic [WB_W-1:0]     wbInData;
  logic [WB_W-1:0]     wbOutData;
  logic                carry_q;
  logic                error_q;

  // selected channel view; each channel keeps its own wires, no arbitration
  assign idle        = (state_q == scg_pkg::ST_IDLE);
  assign inAvail     = chInValid[opChannel];
  assign inIsCtrl    = chInCtrl[opChannel];
  assign outFull     = chOutFull[opChannel];
  assign tagMismatch = inIsCtrl != opControl;

  // reads go when a word is there or when non-blocking; the result buffer can still
  // hold the pipeline back, so a full write-back path also stalls non-blocking reads
  assign getGo    = opValid && !opPut && idle && wbInReady && (inAvail || opNonBlock);
  assign putGo    = opValid && opPut && idle && (!outFull || opNonBlock);
  assign tookWord = getGo && inAvail;
  assign putOk    = putGo && !outFull;
  assign opReady  = getGo || putGo;
  assign chOneHot = chSel(opChannel);
  assign chInRead = tookWord ? chOneHot : '0;

  // accept in cycle 0, complete in cycle 1: two cycles per operation
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      scg_pkg::ST_IDLE: begin
        if (opReady) begin
          state_d = scg_pkg::ST_DONE;
        end
      end
      scg_pkg::ST_DONE: begin
        state_d = scg_pkg::ST_IDLE;
      end
      default: begin
        state_d = scg_pkg::ST_IDLE;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= scg_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign opDone = (state_q == scg_pkg::ST_DONE);

  // carry follows only non-blocking operations; blocking ones leave it alone
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      carry_q <= scg_pkg::CARRY_RESET;
    end else if (opReady && opNonBlock) begin
      carry_q <= opPut ? putOk : tookWord;
    end
  end

  // sticky error; a mismatch in the clearing cycle wins over the clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      error_q <= scg_pkg::ERROR_RESET;
    end else if (tookWord && tagMismatch) begin
      error_q <= 1'b1;
    end else if (errClear) begin
      error_q <= 1'b0;
    end
  end

  // status word image; bit 0 is wired to the same flop as the carry bit
  always_comb begin
    statusWord                     = scg_pkg::STATUS_RESET;
    statusWord[scg_pkg::CARRY_BIT] = carry_q;
    statusWord[scg_pkg::ERROR_BIT] = error_q;
    statusWord[scg_pkg::CARRY_CPY] = carry_q;
  end
  assign carryFlag = carry_q;
  assign errorFlag = error_q;

  // output channel registers, one set per channel so the links never share state
  genvar g;
  generate
    for (g = 0; g < scg_pkg::NUM_CH; g++) begin : gOut
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          chOutData[g]  <= '0;
          chOutCtrl[g]  <= 1'b0;
          chOutWrite[g] <= 1'b0;
        end else begin
          chOutWrite[g] <= putOk && chOneHot[g];
          if (putOk && chOneHot[g]) begin
            chOutData[g] <= opWord;
            chOutCtrl[g] <= opControl;
          end
        end
      end
    end
  endgenerate

  // failed reads still write back zero so the pipeline sees a defined register value
  assign wbInData = {opTarget, tookWord ? chInData[opChannel] : {scg_pkg::DATA_W{1'b0}}};

  scg_fifo #(
    .WIDTH (WB_W),
    .DEPTH (scg_pkg::FIFO_DEPTH)
  ) uWbFifo (
    .clk      (clk),
    .nrst     (nrst),
    .inValid  (getGo),
    .inReady  (wbInReady),
    .inData   (wbInData),
    .outValid (wbValid),
    .outReady (wbReady),
    .outData  (wbOutData)
  );

  assign wbTarget = wbOutData[WB_W-1:scg_pkg::DATA_W];
  assign wbWord   = wbOutData[scg_pkg::DATA_W-1:0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // instruction port: acceptance, stalls and the two-cycle cadence
  accept_then_done_a: assert property (opReady |=> opDone ##1 !opDone)
    else $error("operation did not complete in two cycles");

  busy_refuse_a: assert property (opDone |-> !opReady)
    else $error("request taken while the previous one was finishing");

  nb_get_nostall_a: assert property (
    opValid && !opPut && opNonBlock && idle && wbInReady |-> opReady)
    else $error("non-blocking read stalled");

  nb_ctrl_read_a: assert property (
    opValid && !opPut && opNonBlock && opControl && idle && wbInReady |-> opReady)
    else $error("non-blocking control read stalled");

  blk_get_stall_a: assert property (
    opValid && !opPut && !opNonBlock && !inAvail |-> !opReady && chInRead == '0)
    else $error("blocking read went ahead on an empty channel");

  data_read_stall_a: assert property (
    opValid && !opPut && !opNonBlock && !opControl && !inAvail |-> !opReady)
    else $error("blocking data read went ahead on an empty channel");

  blk_read_go_a: assert property (
    opValid && !opPut && idle && wbInReady && inAvail |-> opReady && chInRead == chOneHot)
    else $error("read held back although a word was waiting");

  read_has_word_a: assert property ((chInRead & ~chInValid) == '0)
    else $error("word consumed from an empty channel");

  read_sel_a: assert property (
    chInRead != '0 |-> chInRead == chOneHot)
    else $error("read strobe on a channel that was not selected");

  nb_get_fail_a: assert property (
    getGo && !inAvail |-> chInRead == '0)
    else $error("failed read consumed a word");

  // stream error and carry flags
  ctrl_in_err_a: assert property (
    tookWord && inIsCtrl && !opControl |=> errorFlag)
    else $error("control word read as data did not raise error");

  data_read_err_a: assert property (
    tookWord && !opNonBlock && !opControl && inIsCtrl |=> errorFlag)
    else $error("blocking data read of a control word did not raise error");

  data_in_err_a: assert property (
    tookWord && !inIsCtrl && opControl |=> errorFlag)
    else $error("data word read as control did not raise error");

  nb_ctrl_err_a: assert property (
    tookWord && opNonBlock && opControl && !inIsCtrl |=> errorFlag)
    else $error("non-blocking control read of a data word did not raise error");

  err_sticky_a: assert property (
    errorFlag && !errClear |=> errorFlag)
    else $error("error flag dropped without a clear");

  err_clear_a: assert property (
    errClear && !(tookWord && tagMismatch) |=> !errorFlag)
    else $error("error flag survived a clear");

  carry_copy_a: assert property (
    statusWord[scg_pkg::CARRY_CPY] == statusWord[scg_pkg::CARRY_BIT] && carryFlag == statusWord[0])
    else $error("status bit 0 differs from carry");

  status_err_a: assert property (statusWord[scg_pkg::ERROR_BIT] == errorFlag)
    else $error("status error bit differs from error flag");

  status_rest_a: assert property (
    statusWord[31:30] == 2'h0 && !statusWord[28] && statusWord[26:1] == 26'h0000000)
    else $error("unused status bits are not zero");

  nb_get_carry_a: assert property (
    opReady && opNonBlock && !opPut |=> carryFlag == $past(inAvail))
    else $error("carry does not reflect read success");

  carry_hold_a: assert property (
    !(opReady && opNonBlock) |=> $stable(carryFlag))
    else $error("carry changed without a non-blocking operation");

  // output channels
  blk_put_stall_a: assert property (
    opValid && opPut && !opNonBlock && outFull |-> !opReady ##1 chOutWrite == '0)
    else $error("blocking write went ahead while full");

  ctrl_put_stall_a: assert property (
    opValid && opPut && !opNonBlock && opControl && outFull |-> !opReady)
    else $error("blocking control write went ahead while full");

  blk_put_go_a: assert property (
    opValid && opPut && !opNonBlock && idle && !outFull |-> opReady)
    else $error("blocking write held back although the channel had room");

  nb_put_nostall_a: assert property (
    opValid && opPut && opNonBlock && idle |-> opReady)
    else $error("non-blocking write stalled");

  nb_ctrl_put_a: assert property (
    opValid && opPut && opNonBlock && opControl && idle |-> opReady)
    else $error("non-blocking control write stalled");

  nb_put_carry_a: assert property (
    opReady && opNonBlock && opPut |=> carryFlag == !$past(outFull))
    else $error("carry does not reflect write acceptance");

  nb_put_full_a: assert property (
    opReady && opNonBlock && opPut && outFull |=> chOutWrite == '0 && !carryFlag)
    else $error("refused write still strobed or set carry");

  put_tag_a: assert property (
    putOk |=> chOutWrite[$past(opChannel)] && chOutCtrl[$past(opChannel)] == $past(opControl))
    else $error("written word carries the wrong tag or no strobe");

  data_tag_low_a: assert property (
    putOk && !opControl |=> !chOutCtrl[$past(opChannel)])
    else $error("data write left the tag high");

  ctrl_tag_high_a: assert property (
    putOk && opControl |=> chOutCtrl[$past(opChannel)])
    else $error("control write left the tag low");

  put_word_a: assert property (
    putOk |=> chOutData[$past(opChannel)] == $past(opWord))
    else $error("written word differs from the requested word");

  out_quiet_a: assert property (
    !putOk |=> chOutWrite == '0)
    else $error("write strobe without an accepted write");

  // write-back path
  wb_push_a: assert property (
    getGo |=> wbValid)
    else $error("accepted read left no write-back entry");

  wb_word_a: assert property (
    tookWord && !wbValid |=> wbWord == $past(chInData[opChannel]) && wbTarget == $past(opTarget))
    else $error("write-back entry differs from the word read");

  write_onehot_a: assert property ($onehot0(chOutWrite) && $onehot0(chInRead))
    else $error("more than one channel strobed at once");
endmodule
`default_nettype wire

/* scg_pkg.sv */
// shared constants and types for the stream channel get/put unit
package scg_pkg;
  localparam int          NUM_CH       = 8;   // input and output channel count
  localparam int          CH_W         = 3;   // channel index width
  localparam int          DATA_W       = 32;  // stream word width
  localparam int          TGT_W        = 5;   // target register index width
  localparam int          FIFO_DEPTH   = 32;  // write-back buffer depth
  localparam int          CARRY_BIT    = 29;  // carry position in status word
  localparam int          ERROR_BIT    = 27;  // stream error position in status word
  localparam int          CARRY_CPY    = 0;   // carry copy position in status word
  localparam int          OP_CYCLES    = 2;   // cycles from accept to completion
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic        CARRY_RESET  = 1'b0;
  localparam logic        ERROR_RESET  = 1'b0;

  // operation sequencer, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DONE = 2'b10
  } scg_state_t;
endpackage

/* scg_fifo.sv */
// parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module scg_fifo #(
  parameter int WIDTH = 37,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      rdPtr_q;
  logic             empty;
  logic             full;

  // extra pointer bit tells full from empty when the indices meet
  assign empty    = (wrPtr_q == rdPtr_q);
  assign full     = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr_q[AW-1:0]];

  // storage has no reset; contents only matter behind the pointers
  always_ff @(posedge clk) begin
    if (inValid && !full) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  // write pointer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr_q <= '0;
    end else if (inValid && !full) begin
      wrPtr_q <= wrPtr_q + 1'b1;
    end
  end

  // read pointer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdPtr_q <= '0;
    end else if (outReady && !empty) begin
      rdPtr_q <= rdPtr_q + 1'b1;
    end
  end
endmodule
`default_nettype wire

/* scg_far_model.sv */
// far-side model: one-word sources on input channels, full-driven sinks on outputs
`timescale 1ns/100ps
`default_nettype none
module scg_far_model (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [7:0]       loadEn,
  input  wire logic [31:0]      loadWord,
  input  wire logic             loadCtrl,
  input  wire logic [7:0]       fullMask,
  input  wire logic [7:0]       chInRead,
  output logic      [7:0]       chInValid,
  output logic      [7:0][31:0] chInData,
  output logic      [7:0]       chInCtrl,
  output logic      [7:0]       chOutFull
);
  logic [7:0][31:0] slotData_q;
  logic [7:0]       slotCtrl_q;
  // a word and its tag stay put until the unit consumes them
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chInValid  <= 8'h00;
      slotData_q <= '0;
      slotCtrl_q <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (loadEn[i]) begin
          chInValid[i]  <= 1'b1;
          slotData_q[i] <= loadWord;
          slotCtrl_q[i] <= loadCtrl;
        end else if (chInRead[i]) begin
          chInValid[i] <= 1'b0;
        end
      end
    end
  end
  // empty source shows inverted lines, so a stale word can never pass for a fresh one
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      chInData[i] = chInValid[i] ? slotData_q[i] : ~slotData_q[i];
      chInCtrl[i] = chInValid[i] ? slotCtrl_q[i] : ~slotCtrl_q[i];
    end
  end
  assign chOutFull = fullMask;
endmodule
`default_nettype wire

/* scg_unit_tb.sv */
// self-checking bench for the stream channel get/put unit
`timescale 1ns/100ps
`default_nettype none
module scg_unit_tb;
  logic             clk = 1'b0, nrst = 1'b0, opValid = 1'b0, opPut = 1'b0;
  logic             opNonBlock = 1'b0, opControl = 1'b0, errClear = 1'b0, wbReady = 1'b0;
  logic             loadCtrl = 1'b0, expCarry = 1'b0, expErr = 1'b0;
  logic             opReady, opDone, carryFlag, errorFlag, wbValid;
  logic [2:0]       opChannel = 3'h0;
  logic [4:0]       opTarget = 5'h00;
  logic [4:0]       wbTarget;
  logic [31:0]      opWord = 32'h0000_0000, loadWord = 32'h0000_0000, seed = 32'h54C59792;
  logic [31:0]      statusWord, wbWord;
  logic [7:0]       loadEn = 8'h00, fullMask = 8'h00;
  logic [7:0]       chInValid, chInCtrl, chInRead, chOutFull, chOutCtrl, chOutWrite;
  logic [7:0][31:0] chInData, chOutData;
  logic [36:0]      q[$];
  int               error_cnt = 0, comparisons = 0;

  scg_unit DUT (.clk, .nrst, .opValid, .opPut, .opNonBlock, .opControl, .opChannel,
    .opTarget, .opWord, .opReady, .opDone, .chInValid, .chInData, .chInCtrl, .chInRead,
    .chOutFull, .chOutData, .chOutCtrl, .chOutWrite, .errClear, .carryFlag, .errorFlag,
    .statusWord, .wbValid, .wbReady, .wbTarget, .wbWord);
  scg_far_model farEnd (.clk, .nrst, .loadEn, .loadWord, .loadCtrl, .fullMask, .chInRead,
    .chInValid, .chInData, .chInCtrl, .chOutFull);

  initial begin
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // status image: carry at 29 and 0, error at 27
  function automatic logic [31:0] status_of(input logic c, input logic e);
    status_of = 32'h0000_0000;
    status_of[29] = c;
    status_of[27] = e;
    status_of[0] = c;
  endfunction

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // take one write-back entry at the edge where wbReady is high
  task automatic pop_one();
    chk("writeback", {wbValid, wbTarget, wbWord}, {1'b1, q.pop_front()});
    wbReady = 1'b1;
    tick();
    wbReady = 1'b0;
  endtask

  // one get or put; avail low means empty source or full sink, released after a stall
  task automatic do_op(input logic put, nb, ctl, input logic [2:0] ch, input logic avail);
    logic [31:0] w;
    logic [31:0] d;
    logic        hit;
    logic        ok;
    int          i;
    w = xs();
    d = xs();
    hit = 1'b0;
    ok = avail || !nb;
    opPut = put;
    opNonBlock = nb;
    opControl = ctl;
    opChannel = ch;
    opTarget = w[4:0];
    opWord = w;
    fullMask = d[7:0];
    fullMask[ch] = put && !avail;
    loadWord = d;
    loadCtrl = d[31];
    if (!put && avail) begin
      loadEn[ch] = 1'b1;
      tick();
      loadEn = 8'h00;
    end
    opValid = 1'b1;
    // a full write-back buffer holds reads off until one entry leaves
    if (!put && q.size() == 32) begin
      repeat (3) begin
        @(negedge clk);
        chk("ready buffer full", opReady, 0);
      end
      tick();
      pop_one();
    end
    for (i = 0; i < 20 && !hit; i++) begin
      @(negedge clk);
      hit = opReady;
      if (hit) chk("read strobe", chInRead, (put || !ok) ? 8'h00 : 8'h01 << ch);
      tick();
      loadEn = 8'h00;
      if (!hit && i == 2) begin
        loadEn[ch] = !put;
        fullMask[ch] = 1'b0;
      end
    end
    opValid = 1'b0;
    if (!hit) begin
      error_cnt++;
      close_out();
    end
    // a released source shows its word one edge later than a released sink drops full
    chk("accept cycles", i,
      ok && avail || nb ? 1 : (put ? 4 : 5));
    @(negedge clk);
    chk("done pulse", opDone, 1);
    if (put) begin
      chk("write strobe", chOutWrite, ok ? 8'h01 << ch : 8'h00);
      if (ok) chk("word and tag", {chOutCtrl[ch], chOutData[ch]}, {ctl, w});
    end else begin
      q.push_back({w[4:0], ok ? d : 32'h0000_0000});
      if (ok && d[31] != ctl) expErr = 1'b1;
    end
    if (nb) expCarry = ok;
    chk("flags", {carryFlag, errorFlag, statusWord},
      {expCarry, expErr, status_of(expCarry, expErr)});
    tick();
  endtask

  initial begin
    logic [31:0] r;
    repeat (2) @(posedge clk);
    #1;
    chk("reset", {carryFlag, errorFlag, wbValid, opDone, chInRead, chOutWrite, statusWord}, 0);
    nrst = 1'b1;
    // every get and put variant, not ready on channel 0 and ready on channel 7
    for (int k = 0; k < 16; k++) begin
      do_op(k[0], k[1], k[2], k[3] ? 3'h7 : 3'h0, k[3]);
    end
    $display("test corner variants done");
    for (int n = 0; n < 150; n++) begin
      r = xs();
      do_op(r[0], r[1], r[2], r[5:3], r[6] | r[7]);
      if (r[10:8] == 3'h0) begin
        errClear = 1'b1;
        tick();
        errClear = 1'b0;
        expErr = 1'b0;
      end
    end
    while (q.size() > 0) pop_one();
    chk("buffer empty", wbValid, 0);
    $display("test random ops and drain done");
    close_out();
  end
endmodule
`default_nettype wire
